// ### src/supply_cmd_pkg.sv
// constants for the supply command block: register map, fields, reset values
// assumes a 32-bit apb master with byte addresses on paddr
`default_nettype none
package supply_cmd_pkg;
    // byte offsets
    localparam logic [7:0] CONFIG_OFS     = 8'h00;
    localparam logic [7:0] CMD_OFS        = 8'h04;
    localparam logic [7:0] VSET_OFS       = 8'h08;
    localparam logic [7:0] ISET_OFS       = 8'h0c;
    localparam logic [7:0] VEFF_OFS       = 8'h10;
    localparam logic [7:0] IEFF_OFS       = 8'h14;
    localparam logic [7:0] FMASK_OFS      = 8'h18;
    localparam logic [7:0] FMASK_NAME_OFS = 8'h1c;
    localparam logic [7:0] FAULT_OFS      = 8'h20;
    localparam logic [7:0] STATUS_OFS     = 8'h24;
    localparam logic [7:0] MEAS_LO_OFS    = 8'h28;
    localparam logic [7:0] MEAS_HI_OFS    = 8'h2c;
    localparam logic [7:0] SLOPE_OFS      = 8'h30;
    localparam logic [7:0] OFFSET_OFS     = 8'h34;
    localparam logic [7:0] IRQ_STAT_OFS   = 8'h38;
    localparam logic [7:0] IRQ_MASK_OFS   = 8'h3c;
    // config and command bits
    localparam int CFG_HOLD_BIT    = 0;
    localparam int CFG_CALMODE_BIT = 1;
    localparam int CMD_TRIGGER_BIT = 0;
    localparam int CMD_CAL_LO_BIT  = 1;
    localparam int CMD_CAL_HI_BIT  = 2;
    localparam int CMD_COMPUTE_BIT = 3;
    localparam int CMD_CLR_ERR_BIT = 4;
    localparam int NAME_NEW_BIT    = 8;
    // condition bit positions
    localparam int COND_W              = 13;
    localparam int CONSTANT_VOLTAGE_COND  = 0;
    localparam int CONSTANT_CURRENT_COND  = 1;
    localparam int OVERVOLTAGE_TRIP_COND  = 3;
    localparam int OVERTEMP_TRIP_COND     = 4;
    localparam int EXTERNAL_SHUTDOWN_COND = 5;
    localparam int FOLDBACK_COND          = 6;
    localparam int PROG_ERROR_COND        = 7;
    localparam int POWER_ON_COND          = 8;
    localparam int REMOTE_MODE_COND       = 9;
    localparam int AC_FAIL_COND           = 10;
    localparam int OUTPUT_FAIL_COND       = 11;
    localparam int SENSE_PROTECTION_COND  = 12;
    localparam logic [3:0] NAME_ALL  = 4'hd;
    localparam logic [3:0] NAME_NONE = 4'he;
    localparam logic [12:0] MASK_ALL   = 13'h1_ffb;
    localparam logic [12:0] MASK_RESET = 13'h0_000;
    // status extra bits
    localparam int STS_BUSY_BIT    = 16;
    localparam int STS_ERR_BIT     = 17;
    localparam int STS_CALPT_LSB   = 18;
    // irq event bits
    localparam int IRQ_W          = 4;
    localparam int IRQ_FAULT_BIT  = 0;
    localparam int IRQ_REJECT_BIT = 1;
    localparam int IRQ_TRIG_BIT   = 2;
    localparam int IRQ_CALDN_BIT  = 3;
    // calibration drive codes and divider length
    localparam logic [15:0] CAL_LO_CODE = 16'h0100;
    localparam logic [15:0] CAL_HI_CODE = 16'hf000;
    localparam logic [5:0]  DIV_STEPS   = 6'h20;
    localparam logic [15:0] SET_RESET   = 16'h0000;
    typedef enum logic [2:0] {
        CP_NONE = 3'b001,
        CP_LO   = 3'b010,
        CP_HI   = 3'b100
    } cal_pt_t;
endpackage : supply_cmd_pkg
`default_nettype wire

// ### src/supply_cmd_trigger_mask_cal.sv
// supply command block: held settings with trigger, fault mask, voltage calibration
// assumes apb master per amba apb, status_in synchronous to pclk
`default_nettype none
module supply_cmd_trigger_mask_cal
    import supply_cmd_pkg::*;
#(
    parameter int DW = 16
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [COND_W-1:0] status_in,
    output logic      [DW-1:0]     vprog_out,
    output logic      [DW-1:0]     iprog_out,
    output logic                   irq
);
    typedef struct packed {
        logic              pready;
        logic              pslverr;
        logic [31:0]       prdata;
        logic              hold;
        logic              cal_mode;
        logic [DW-1:0]     vset_pend;
        logic [DW-1:0]     iset_pend;
        logic [DW-1:0]     veff;
        logic [DW-1:0]     ieff;
        logic [DW-1:0]     vout;
        cal_pt_t           cal_pt;
        logic [COND_W-1:0] fmask;
        logic [COND_W-1:0] fault;
        logic [COND_W-1:0] stat_prev;
        logic              err;
        logic [15:0]       meas_lo;
        logic [15:0]       meas_hi;
        logic              busy;
        logic              post;
        logic [5:0]        div_cnt;
        logic [15:0]       den;
        logic [16:0]       remd;
        logic [31:0]       num;
        logic [31:0]       quo;
        logic [31:0]       slope;
        logic [31:0]       offset;
        logic [IRQ_W-1:0]  irq_stat;
        logic [IRQ_W-1:0]  irq_mask;
        logic              irq;
    } state_t;

    state_t s_q;
    state_t s_d;

    logic              wr_acc;
    logic              rd_acc;
    logic              cmd_wr;
    logic              cal_cmd;
    logic [COND_W-1:0] stat_now;
    logic [COND_W-1:0] stat_rise;

    assign wr_acc    = psel && penable && s_q.pready && pwrite;
    assign rd_acc    = psel && penable && s_q.pready && !pwrite;
    assign cmd_wr    = wr_acc && (paddr == CMD_OFS);
    assign cal_cmd   = cmd_wr && (pwdata[CMD_CAL_LO_BIT] || pwdata[CMD_CAL_HI_BIT]
                                  || pwdata[CMD_COMPUTE_BIT]);
    // own programming error shows up as a status condition like any other
    assign stat_now  = status_in | (COND_W'(s_q.err) << PROG_ERROR_COND);
    assign stat_rise = stat_now & ~s_q.stat_prev;

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a[1:0] == 2'b00) && (a <= IRQ_MASK_OFS);
    endfunction

    always_comb
    begin
        logic [16:0]      remd_sh;
        logic [47:0]      prod;
        logic [IRQ_W-1:0] ev;
        logic             reject;
        remd_sh = 17'h0_0000;
        prod   = 48'h0000_0000_0000;
        ev     = '0;
        reject = 1'b0;
        s_d    = s_q;

        // one wait state: pready rises in the second access cycle
        s_d.pready  = psel && penable && !s_q.pready;
        s_d.pslverr = psel && penable && !s_q.pready && !mapped(paddr);
        s_d.prdata  = 32'h0000_0000;
        if (psel && penable && !s_q.pready && !pwrite)
        begin
            unique case (paddr)
                CONFIG_OFS:  s_d.prdata = 32'({s_q.cal_mode, s_q.hold});
                VSET_OFS:    s_d.prdata = 32'(s_q.vset_pend);
                ISET_OFS:    s_d.prdata = 32'(s_q.iset_pend);
                VEFF_OFS:    s_d.prdata = 32'(s_q.veff);
                IEFF_OFS:    s_d.prdata = 32'(s_q.ieff);
                FMASK_OFS:   s_d.prdata = 32'(s_q.fmask);
                FAULT_OFS:   s_d.prdata = 32'(s_q.fault);
                STATUS_OFS:  s_d.prdata = 32'(stat_now)
                                        | (32'(s_q.busy) << STS_BUSY_BIT)
                                        | (32'(s_q.err) << STS_ERR_BIT)
                                        | (32'(s_q.cal_pt) << STS_CALPT_LSB);
                MEAS_LO_OFS: s_d.prdata = 32'(s_q.meas_lo);
                MEAS_HI_OFS: s_d.prdata = 32'(s_q.meas_hi);
                SLOPE_OFS:   s_d.prdata = s_q.slope;
                OFFSET_OFS:  s_d.prdata = s_q.offset;
                IRQ_STAT_OFS: s_d.prdata = 32'(s_q.irq_stat);
                IRQ_MASK_OFS: s_d.prdata = 32'(s_q.irq_mask);
                default:     s_d.prdata = 32'h0000_0000;
            endcase
        end

        if (wr_acc)
        begin
            unique case (paddr)
                CONFIG_OFS:
                begin
                    s_d.hold     = pwdata[CFG_HOLD_BIT];
                    s_d.cal_mode = pwdata[CFG_CALMODE_BIT];
                    if (!pwdata[CFG_CALMODE_BIT])
                        s_d.cal_pt = CP_NONE;
                end
                VSET_OFS:
                begin
                    s_d.vset_pend = pwdata[DW-1:0];
                    if (!s_q.hold)
                        s_d.veff = pwdata[DW-1:0];
                end
                ISET_OFS:
                begin
                    s_d.iset_pend = pwdata[DW-1:0];
                    if (!s_q.hold)
                        s_d.ieff = pwdata[DW-1:0];
                end
                FMASK_OFS:   s_d.fmask = pwdata[COND_W-1:0] & MASK_ALL;
                FMASK_NAME_OFS:
                begin
                    // names OR into the mask, so arrival order is irrelevant
                    if (pwdata[NAME_NEW_BIT])
                        s_d.fmask = MASK_RESET;
                    if (pwdata[3:0] == NAME_ALL)
                        s_d.fmask = MASK_ALL;
                    else if (pwdata[3:0] == NAME_NONE)
                        s_d.fmask = MASK_RESET;
                    else if (MASK_ALL[pwdata[3:0]] && (pwdata[3:0] < 4'(COND_W)))
                        s_d.fmask[pwdata[3:0]] = 1'b1;
                    else
                        s_d.err = 1'b1;
                end
                MEAS_LO_OFS: s_d.meas_lo = pwdata[15:0];
                MEAS_HI_OFS: s_d.meas_hi = pwdata[15:0];
                IRQ_MASK_OFS: s_d.irq_mask = pwdata[IRQ_W-1:0];
                default: ;
            endcase
        end

        if (cmd_wr)
        begin
            if (pwdata[CMD_CLR_ERR_BIT])
                s_d.err = 1'b0;
            if (pwdata[CMD_TRIGGER_BIT])
            begin
                s_d.veff = s_q.vset_pend;
                s_d.ieff = s_q.iset_pend;
                ev[IRQ_TRIG_BIT] = 1'b1;
            end
            if (cal_cmd && !s_q.cal_mode)
                reject = 1'b1;
            else if (s_q.cal_mode)
            begin
                if (pwdata[CMD_CAL_HI_BIT])
                    s_d.cal_pt = CP_HI;
                else if (pwdata[CMD_CAL_LO_BIT])
                    s_d.cal_pt = CP_LO;
                if (pwdata[CMD_COMPUTE_BIT] && !s_q.busy)
                begin
                    if (s_q.meas_hi <= s_q.meas_lo)
                        reject = 1'b1;
                    else
                    begin
                        s_d.busy    = 1'b1;
                        s_d.div_cnt = DIV_STEPS;
                        s_d.den     = s_q.meas_hi - s_q.meas_lo;
                        s_d.num     = {CAL_HI_CODE - CAL_LO_CODE, 16'h0000};
                        s_d.remd    = 17'h0_0000;
                        s_d.quo     = 32'h0000_0000;
                    end
                end
            end
        end
        if (reject)
        begin
            s_d.err = 1'b1;
            ev[IRQ_REJECT_BIT] = 1'b1;
        end

        // restoring divider, one quotient bit a cycle, then offset in one cycle
        if (s_q.busy && !s_q.post)
        begin
            remd_sh = {s_q.remd[15:0], s_q.num[31]};
            s_d.num = {s_q.num[30:0], 1'b0};
            if (remd_sh >= {1'b0, s_q.den})
            begin
                s_d.remd = remd_sh - {1'b0, s_q.den};
                s_d.quo  = {s_q.quo[30:0], 1'b1};
            end
            else
            begin
                s_d.remd = remd_sh;
                s_d.quo = {s_q.quo[30:0], 1'b0};
            end
            s_d.div_cnt = s_q.div_cnt - 6'h01;
            if (s_q.div_cnt == 6'h01)
                s_d.post = 1'b1;
        end
        else if (s_q.busy)
        begin
            prod       = s_q.quo * {16'h0000, s_q.meas_lo};
            s_d.slope  = s_q.quo;
            s_d.offset = 32'(CAL_LO_CODE) - prod[47:16];
            s_d.busy   = 1'b0;
            s_d.post   = 1'b0;
            ev[IRQ_CALDN_BIT] = 1'b1;
        end

        // fault latch: clear by write-one, a new rise in the same cycle wins
        s_d.stat_prev = stat_now;
        if (wr_acc && (paddr == FAULT_OFS))
            s_d.fault = s_q.fault & ~pwdata[COND_W-1:0];
        s_d.fault = s_d.fault | (stat_rise & s_q.fmask);
        if (|(stat_rise & s_q.fmask))
            ev[IRQ_FAULT_BIT] = 1'b1;

        // calibration points override the effective voltage setting only while active; the current output stays on ieff
        unique case (s_d.cal_pt)
            CP_LO:   s_d.vout = CAL_LO_CODE[DW-1:0];
            CP_HI:   s_d.vout = CAL_HI_CODE[DW-1:0];
            CP_NONE: s_d.vout = s_d.veff;
            default: s_d.vout = s_d.veff;
        endcase

        if (wr_acc && (paddr == IRQ_STAT_OFS))
            s_d.irq_stat = s_q.irq_stat & ~pwdata[IRQ_W-1:0];
        s_d.irq_stat = s_d.irq_stat | ev;
        s_d.irq      = |(s_d.irq_stat & s_d.irq_mask);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_q           <= '0;
            s_q.cal_pt    <= CP_NONE;
            s_q.fmask     <= MASK_RESET;
            s_q.vset_pend <= SET_RESET[DW-1:0];
            s_q.iset_pend <= SET_RESET[DW-1:0];
            s_q.veff      <= SET_RESET[DW-1:0];
            s_q.ieff      <= SET_RESET[DW-1:0];
            s_q.vout      <= SET_RESET[DW-1:0];
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign prdata    = s_q.prdata;
    assign pready    = s_q.pready;
    assign pslverr   = s_q.pslverr;
    assign vprog_out = s_q.vout;
    assign iprog_out = s_q.ieff;
    assign irq       = s_q.irq;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic trig_acc;
    logic cal_on_cmd;
    assign trig_acc   = cmd_wr && pwdata[CMD_TRIGGER_BIT];
    assign cal_on_cmd = cmd_wr && s_q.cal_mode;

    a_trigger_applies: assert property (
        trig_acc |=> (s_q.veff == $past(s_q.vset_pend)) && (s_q.ieff == $past(s_q.iset_pend)))
        else $error("trigger did not apply held settings");
    a_hold_keeps_eff: assert property (
        s_q.hold && !trig_acc |=> $stable(s_q.veff) && $stable(s_q.ieff))
        else $error("effective setting changed while held");
    a_fault_latches: assert property (
        |(stat_rise & s_q.fmask) |=> (s_q.fault & $past(stat_rise & s_q.fmask))
                                     == $past(stat_rise & s_q.fmask))
        else $error("masked rising status did not latch");
    a_fault_cause: assert property (
        1'b1 |=> ((s_q.fault & ~$past(s_q.fault)) & ~$past(stat_rise & s_q.fmask)) == '0)
        else $error("fault bit set without masked rise");
    a_mask_after_reset: assert property (@(posedge pclk) disable iff (1'b0)
        !presetn |=> (s_q.fmask == MASK_RESET))
        else $error("mask not clear after reset");
    a_mask_readback: assert property (
        rd_acc && (paddr == FMASK_OFS) |-> prdata == 32'(s_q.fmask))
        else $error("mask query mismatch");
    a_name_any_order: assert property (
        wr_acc && (paddr == FMASK_NAME_OFS) && !pwdata[NAME_NEW_BIT] && (pwdata[3:0] < 4'hd)
        && MASK_ALL[pwdata[3:0]] |=> (s_q.fmask & $past(s_q.fmask)) == $past(s_q.fmask))
        else $error("name write dropped earlier names");
    a_mask_sum_write: assert property (
        wr_acc && (paddr == FMASK_OFS) |=> s_q.fmask == ($past(pwdata[COND_W-1:0]) & MASK_ALL))
        else $error("mask weight sum not stored");
    a_cal_reject: assert property (
        cal_cmd && !s_q.cal_mode |=> s_q.err && $stable(s_q.slope) && !s_q.busy)
        else $error("calibration accepted outside calibration mode");
    a_cal_hi_drive: assert property (
        cal_on_cmd && pwdata[CMD_CAL_HI_BIT] |=> vprog_out == CAL_HI_CODE[DW-1:0])
        else $error("high point not driven");
    a_cal_lo_drive: assert property (
        cal_on_cmd && pwdata[CMD_CAL_LO_BIT] && !pwdata[CMD_CAL_HI_BIT]
        |=> vprog_out == CAL_LO_CODE[DW-1:0])
        else $error("low point not driven");
    a_compute_ends: assert property (
        $rose(s_q.busy) |-> s_q.busy [*8] ##25 s_q.busy
                            ##1 (!s_q.busy && s_q.irq_stat[IRQ_CALDN_BIT]))
        else $error("calibration compute did not finish");
    a_irq_level: assert property (
        1'b1 |=> irq == |($past(s_d.irq_stat) & $past(s_d.irq_mask)))
        else $error("interrupt level wrong");

    c_trigger: cover property (s_q.hold ##1 trig_acc);
    c_fault: cover property (|(stat_rise & s_q.fmask));
    c_compute: cover property ($fell(s_q.busy));
    c_reject: cover property (cal_cmd && !s_q.cal_mode);
endmodule : supply_cmd_trigger_mask_cal
`default_nettype wire

// ### test/apb_host_model.sv
// apb master standing in for the host controller of the supply
// assumes pclk from the bench; one transfer at a time, no timeout of its own
`default_nettype none
module apb_host_model (
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0000_0000;
    end

    // request held until pready is seen at a rising edge
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // released data lines carry no stale word
        pwdata  <= ~d;
    endtask
endmodule // apb_host_model
`default_nettype wire

// ### test/tb_top.sv
// self-checking bench for the supply command block
// assumes the apb host model in its own file; one clock at 25 MHz
`default_nettype none
`define CHK(act, exp) begin cmp_count++; if ((act) !== (exp)) begin fails++; \
    $display("Error at %0t: got %h want %h", $time, (act), (exp)); end end
module tb_top
    import supply_cmd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [12:0] status_in;
    logic [15:0] vprog_out;
    logic [15:0] iprog_out;
    logic        irq;
    logic [31:0] rdata;
    logic        rerr;
    int          fails;
    int          cmp_count;
    integer      seed = 32'h0000_acde;
    int          v, i, mask_m, s, n, lo, hi;
    longint      slope_m, offset_m;
    int          order[12] = '{12, 0, 9, 3, 11, 1, 6, 4, 10, 5, 8, 7};

    supply_cmd_trigger_mask_cal #(.DW(16)) u_supply_cmd_trigger_mask_cal (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .status_in(status_in),
        .vprog_out(vprog_out), .iprog_out(iprog_out), .irq(irq));

    apb_host_model u_apb_host_model (
        .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    initial pclk = 1'b0;
    always #20 pclk = ~pclk;

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        u_apb_host_model.xfer(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [7:0] a);
        u_apb_host_model.xfer(1'b0, a, 32'h0000_0000, rdata, rerr);
    endtask

    // registered outputs land on the edge that accepts the write
    task automatic settle;
        repeat (2) @(posedge pclk);
        #1;
    endtask

    task automatic conclude;
        $display("mismatches %0d comparisons %0d", fails, cmp_count);
        if (fails == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge pclk);
        fails++;
        conclude;
    end

    initial
    begin
        presetn   = 1'b0;
        status_in = 13'h0_000;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        `CHK(vprog_out, 16'h0000)
        rd(FMASK_OFS);
        `CHK(rdata, 32'h0000_0000)
        // held settings and trigger
        wr(CONFIG_OFS, 32'h0000_0001);
        v = $random(seed) & 32'h0000_ffff;
        i = $random(seed) & 32'h0000_ffff;
        wr(VSET_OFS, v);
        wr(ISET_OFS, i);
        settle;
        `CHK(vprog_out, 16'h0000)
        rd(VEFF_OFS);
        `CHK(rdata, 32'h0000_0000)
        wr(CMD_OFS, 32'(1 << CMD_TRIGGER_BIT));
        settle;
        `CHK(vprog_out, 16'(v))
        `CHK(iprog_out, 16'(i))
        rd(IEFF_OFS);
        `CHK(rdata, 32'(i))
        // trigger event raised, masked, cleared
        wr(IRQ_MASK_OFS, 32'(1 << IRQ_TRIG_BIT));
        settle;
        `CHK(irq, 1'b1)
        wr(IRQ_MASK_OFS, 32'h0000_0000);
        settle;
        `CHK(irq, 1'b0)
        wr(IRQ_STAT_OFS, 32'(1 << IRQ_TRIG_BIT));
        wr(IRQ_MASK_OFS, 32'(1 << IRQ_TRIG_BIT));
        settle;
        `CHK(irq, 1'b0)
        rd(8'h40);
        `CHK(rerr, 1'b1)
        `CHK(rdata, 32'h0000_0000)
        // names in scrambled order, first one starts a new list
        mask_m = 0;
        foreach (order[k])
        begin
            wr(FMASK_NAME_OFS, 32'((k == 0 ? 32'h0000_0100 : 0) | order[k]));
            mask_m |= 1 << order[k];
        end
        rd(FMASK_OFS);
        `CHK(rdata, 32'(mask_m))
        wr(FMASK_NAME_OFS, 32'(NAME_NONE));
        rd(FMASK_OFS);
        `CHK(rdata, 32'h0000_0000)
        wr(FMASK_NAME_OFS, 32'(NAME_ALL));
        rd(FMASK_OFS);
        `CHK(rdata, 32'h0000_1ffb)
        wr(FMASK_NAME_OFS, 32'h0000_0002);
        rd(STATUS_OFS);
        `CHK(rdata[STS_ERR_BIT], 1'b1)
        wr(CMD_OFS, 32'(1 << CMD_CLR_ERR_BIT));
        // mask as a weight sum
        s = $random(seed);
        wr(FMASK_OFS, s);
        mask_m = s & 32'h0000_1ffb;
        rd(FMASK_OFS);
        `CHK(rdata, 32'(mask_m))
        // fault latching on masked rising status only
        wr(FAULT_OFS, 32'h0000_1fff);
        s = $random(seed) & 32'h0000_1f7b;
        @(posedge pclk);
        status_in <= 13'(s);
        settle;
        rd(FAULT_OFS);
        `CHK(rdata, 32'(s & mask_m))
        // a level that stays high must not latch again after the clear
        wr(FAULT_OFS, 32'h0000_1fff);
        rd(FAULT_OFS);
        `CHK(rdata, 32'h0000_0000)
        @(posedge pclk);
        status_in <= 13'h0_000;
        settle;
        wr(FAULT_OFS, 32'h0000_1fff);
        rd(FAULT_OFS);
        `CHK(rdata, 32'h0000_0000)
        // calibration outside its mode is refused
        wr(CMD_OFS, 32'(1 << CMD_CAL_LO_BIT));
        settle;
        `CHK(vprog_out, 16'(v))
        rd(STATUS_OFS);
        `CHK(rdata[STS_ERR_BIT], 1'b1)
        rd(IRQ_STAT_OFS);
        `CHK(rdata[IRQ_REJECT_BIT], 1'b1)
        wr(CMD_OFS, 32'(1 << CMD_CLR_ERR_BIT));
        wr(CONFIG_OFS, 32'(1 << CFG_CALMODE_BIT));
        wr(CMD_OFS, 32'(1 << CMD_CAL_LO_BIT));
        settle;
        `CHK(vprog_out, CAL_LO_CODE)
        rd(STATUS_OFS);
        `CHK(rdata[20:18], CP_LO)
        wr(CMD_OFS, 32'(1 << CMD_CAL_HI_BIT));
        settle;
        `CHK(vprog_out, CAL_HI_CODE)
        lo = 32'h0000_0100 + ($random(seed) & 32'h0000_07ff);
        hi = 32'h0000_e000 + ($random(seed) & 32'h0000_0fff);
        wr(MEAS_LO_OFS, lo);
        wr(MEAS_HI_OFS, hi);
        wr(CMD_OFS, 32'(1 << CMD_COMPUTE_BIT));
        n = 0;
        do
        begin
            rd(STATUS_OFS);
            n++;
        end
        while (rdata[STS_BUSY_BIT] !== 1'b0 && n < 100);
        `CHK(rdata[STS_BUSY_BIT], 1'b0)
        slope_m  = (longint'(32'h0000_ef00) << 16) / (hi - lo);
        offset_m = 256 - ((slope_m * lo) >>> 16);
        rd(SLOPE_OFS);
        `CHK(rdata, 32'(slope_m))
        rd(OFFSET_OFS);
        `CHK(rdata, 32'(offset_m))
        rd(IRQ_STAT_OFS);
        `CHK(rdata[IRQ_CALDN_BIT], 1'b1)
        wr(CONFIG_OFS, 32'h0000_0000);
        settle;
        `CHK(vprog_out, 16'(v))
        // second reset in mid-run must bring a full mask back to cleared
        wr(FMASK_NAME_OFS, 32'(NAME_ALL));
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(FMASK_OFS);
        `CHK(rdata, 32'h0000_0000)
        conclude;
    end
endmodule // tb_top
`default_nettype wire
